// File: verilog/flc_pkg.sv
package flc_pkg;
  // Instruction codes understood by the device end.
  localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h21;
  localparam logic [7:0] OPC_LOCK_RD = 8'h22;
  localparam logic [7:0] OPC_LOCK_WR = 8'h23;
  localparam logic [7:0] OPC_FLAG_RD = 8'h24;
  localparam logic [7:0] OPC_FLAG_CLR = 8'h25;
  localparam logic [7:0] OPC_PCFG_RD = 8'h26;
  localparam logic [7:0] OPC_PCFG_WR = 8'h27;
  localparam logic [7:0] OPC_VCFG_RD = 8'h28;
  localparam logic [7:0] OPC_VCFG_WR = 8'h29;
  localparam logic [7:0] OPC_ECFG_RD = 8'h2A;
  // Frame lengths in serial bits.
  localparam logic [5:0] LEN_OPC = 6'd8;
  localparam logic [5:0] LEN_LOCK_ADDR = 6'd32;
  localparam logic [5:0] LEN_LOCK_WR = 6'd40;
  localparam logic [5:0] LEN_VCFG_WR = 6'd16;
  localparam logic [5:0] LEN_PCFG_WR = 6'd24;
  localparam logic [5:0] LEN_MAX = 6'h3F;
  localparam logic [4:0] OUT_LEN_BYTE = 5'd8;
  localparam logic [4:0] OUT_LEN_WORD = 5'd16;
  // Sector lock byte fields and sector decode.
  localparam int LK_WRITE = 0;
  localparam int LK_DOWN = 1;
  localparam int SEC_MSB = 23;
  localparam int SEC_LSB = 16;
  localparam int NUM_SEC = 256;
  localparam logic [1:0] LOCK_RST = 2'h0;
  // Flag status bit positions and error vector order.
  localparam int FS_READY = 7;
  localparam int FS_ERASE = 5;
  localparam int FS_PROG = 4;
  localparam int FS_VPP = 3;
  localparam int FS_PROT = 1;
  localparam int ERR_ERASE = 3;
  localparam int ERR_PROG = 2;
  localparam int ERR_VPP = 1;
  localparam int ERR_PROT = 0;
  // Configuration reset values.
  localparam logic [7:0] VCFG_RST = 8'hFF;
  localparam logic [7:0] ECFG_RST = 8'hFF;
  localparam logic [15:0] PCFG_RST = 16'hFFFF;
  // Timing.
  localparam int CLK_NS = 20;
  localparam int PCFG_WR_NS = 2000;
  localparam int PCFG_WR_CYC = PCFG_WR_NS / CLK_NS;
  localparam int MIN_DESEL_NS = 50;
  localparam int MIN_DESEL_CYC = (MIN_DESEL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF_CYC = 4;
  // Controller register offsets and command fields.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CMD_AB_LSB = 8;
  localparam int CMD_WB_LSB = 10;
  localparam int CMD_RB_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: verilog/flc_spi_if.sv
`timescale 1ns/10ps
interface flc_spi_if;
  logic cs_n;     // Chip select, active low.
  logic sclk;     // Serial clock made by the host.
  logic mosi;     // Serial input line of the device.
  logic miso_o;   // Device output value.
  logic miso_oe;  // Device drives the output line while high.
  logic miso;     // Resolved output line, pulled high when undriven.
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev (input cs_n, input sclk, input mosi, output miso_o, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

// File: verilog/flc_dev.sv
`timescale 1ns/10ps
// What this block does
// - Lock read: opcode then three-byte sector address
// - Address bits captured on serial clock rise
// - Lock byte shifted out on falling edges
// - Chip select high stops output drive
// - Lock read rejected during busy cycle
// - Write-lock bit blocks sector modification
// - Lock-down freezes both bits until power-up
// - Lock write needs write enable latch
// - Lock write: opcode, address, one data byte
// - Lock write only on exact 40-bit frame
// - Lock write immediate, latch cleared quickly
// - Lock write rejected during busy cycle
// - Lock data byte upper bits zero
// - Flag status readable anytime, repeats continuously
// - Flag clear resets four error bits
// - Flag clear ignores and keeps latch
// - Persistent config write: latch, exact 16 bits
// - Persistent write timed, busy, latch cleared
// - Persistent values act after power-up only
// - Volatile config write: latch, exact 8 bits
// - Volatile config applies immediately, clears latch
// - Three configuration registers are readable
// - Host polls busy before new instructions
module flc_dev
  import flc_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link.
  flc_spi_if.dev spi,
  // Array-side status and checks.
  input wire logic ext_busy,
  input wire logic [3:0] err_set,
  input wire logic [23:0] chk_addr,
  output logic chk_allowed,
  // Visible state.
  output logic write_in_progress_flag,
  output logic write_enable_latch,
  output logic [7:0] flag_status,
  output logic [7:0] vcfg,
  output logic [15:0] pcfg_active
);
  // Sector index of a 24-bit address.
  function automatic logic [7:0] sec_of(input logic [23:0] a);
    sec_of = a[SEC_MSB:SEC_LSB];
  endfunction

  logic [2:0] cs_s;  // Chip select synchroniser and edge stage.
  logic [2:0] ck_s;  // Serial clock synchroniser and edge stage.
  logic [1:0] di_s;  // Serial input synchroniser.
  logic [5:0] cnt_ff;  // Bits received in this frame.
  logic [39:0] sh_ff;  // Received bits, newest in bit 0.
  logic [7:0] opc_ff;  // Opcode of this frame.
  logic [1:0] lock_ff [NUM_SEC];  // Per-sector lock bits.
  logic wel_ff;  // Write enable latch.
  logic pbusy_ff;  // Persistent write cycle running.
  logic [15:0] pcnt_ff;  // Persistent write cycle countdown.
  logic [15:0] pcfg_ff = PCFG_RST;  // Persistent store, kept over reset.
  logic [15:0] pact_ff;  // Persistent values in force.
  logic [7:0] vcfg_ff;  // Volatile configuration.
  logic [3:0] err_ff;  // Sticky error flags.
  logic [7:0] fsr_ff;  // Flag status image.
  logic [15:0] osh_ff;  // Output shifter, MSB first.
  logic [4:0] obit_ff;  // Output bits sent of current word.
  logic [4:0] olen_ff;  // Output word length.
  logic drv_ff;  // Output phase active.
  logic miso_ff;  // Output bit.
  logic chk_ff;  // Registered write permission.

  logic sel;
  logic rise;
  logic fall;
  logic cs_up;
  logic busy;
  logic [39:0] nxt_sh;
  logic [5:0] nxt_cnt;
  logic [7:0] fsr_now;

  assign sel = !cs_s[1];
  assign rise = ck_s[1] && !ck_s[2];
  assign fall = !ck_s[1] && ck_s[2];
  assign cs_up = cs_s[1] && !cs_s[2];
  assign busy = ext_busy || pbusy_ff;
  assign nxt_sh = {sh_ff[38:0], di_s[1]};
  assign nxt_cnt = (cnt_ff == LEN_MAX) ? cnt_ff : cnt_ff + 6'd1;

  // Flag status layout assembled from busy and errors.
  always_comb
  begin
    fsr_now = 8'h00;
    fsr_now[FS_READY] = !busy;
    fsr_now[FS_ERASE] = err_ff[ERR_ERASE];
    fsr_now[FS_PROG] = err_ff[ERR_PROG];
    fsr_now[FS_VPP] = err_ff[ERR_VPP];
    fsr_now[FS_PROT] = err_ff[ERR_PROT];
  end

  // Two-stage synchronisers plus one stage for edge detection.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_s <= 3'h7;
      ck_s <= 3'h0;
      di_s <= 2'h0;
    end
    else
    begin
      cs_s <= {cs_s[1:0], spi.cs_n};
      ck_s <= {ck_s[1:0], spi.sclk};
      di_s <= {di_s[0], spi.mosi};
    end
  end

  // Input shifting: opcode, address and data on rising edges.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sel)
    begin
      cnt_ff <= 6'h00;
      sh_ff <= 40'h0;
      opc_ff <= 8'h00;
    end
    else if (rise)
    begin
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      if (nxt_cnt == LEN_OPC)
      begin
        opc_ff <= nxt_sh[7:0];
      end
    end
  end

  // Output shifting: loads after the last input bit, shifts on falling edges.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drv_ff <= 1'b0;
      osh_ff <= 16'h0;
      obit_ff <= 5'h0;
      olen_ff <= OUT_LEN_BYTE;
      miso_ff <= 1'b0;
    end
    else if (!sel)
    begin
      drv_ff <= 1'b0;
    end
    else if (rise && nxt_cnt == LEN_OPC)
    begin
      obit_ff <= 5'h0;
      olen_ff <= OUT_LEN_BYTE;
      case (nxt_sh[7:0])
        OPC_FLAG_RD:
        begin
          drv_ff <= 1'b1;
          osh_ff <= {fsr_now, 8'h00};
        end
        OPC_PCFG_RD:
        begin
          drv_ff <= 1'b1;
          osh_ff <= pcfg_ff;
          olen_ff <= OUT_LEN_WORD;
        end
        OPC_VCFG_RD:
        begin
          drv_ff <= 1'b1;
          osh_ff <= {vcfg_ff, 8'h00};
        end
        OPC_ECFG_RD:
        begin
          drv_ff <= 1'b1;
          osh_ff <= {ECFG_RST, 8'h00};
        end
        default:
        begin
          drv_ff <= 1'b0;
        end
      endcase
    end
    else if (rise && nxt_cnt == LEN_LOCK_ADDR && opc_ff == OPC_LOCK_RD && !busy)
    begin
      drv_ff <= 1'b1;
      osh_ff <= {6'h00, lock_ff[sec_of(nxt_sh[23:0])], 8'h00};
    end
    else if (fall && drv_ff)
    begin
      miso_ff <= osh_ff[15];
      osh_ff <= {osh_ff[14:0], 1'b0};
      obit_ff <= obit_ff + 5'h1;
      if (obit_ff == olen_ff - 5'h1)
      begin
        obit_ff <= 5'h0;
        osh_ff <= (opc_ff == OPC_FLAG_RD) ? {fsr_now, 8'h00} : osh_ff;
      end
    end
  end

  // Sector lock bits, updated at once on a valid write frame.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_SEC; i++)
      begin
        lock_ff[i] <= LOCK_RST;
      end
    end
    else if (cs_up && opc_ff == OPC_LOCK_WR && cnt_ff == LEN_LOCK_WR && wel_ff && !busy &&
             !lock_ff[sec_of(sh_ff[31:8])][LK_DOWN])
    begin
      lock_ff[sec_of(sh_ff[31:8])] <= sh_ff[1:0];
    end
  end

  // Write enable latch: set by unlock, cleared by completed writes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wel_ff <= 1'b0;
    end
    else if (cs_up && opc_ff == OPC_WRITE_UNLOCK && cnt_ff == LEN_OPC && !busy)
    begin
      wel_ff <= 1'b1;
    end
    else if (cs_up && opc_ff == OPC_LOCK_WR && cnt_ff == LEN_LOCK_WR && !busy)
    begin
      wel_ff <= lock_ff[sec_of(sh_ff[31:8])][LK_DOWN] ? wel_ff : 1'b0;
    end
    else if (cs_up && opc_ff == OPC_VCFG_WR && cnt_ff == LEN_VCFG_WR && !busy)
    begin
      wel_ff <= 1'b0;
    end
    else if (pbusy_ff && pcnt_ff == 16'h1)
    begin
      wel_ff <= 1'b0;
    end
  end

  // Persistent configuration write and its self-timed cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pbusy_ff <= 1'b0;
      pcnt_ff <= 16'h0;
    end
    else if (cs_up && opc_ff == OPC_PCFG_WR && cnt_ff == LEN_PCFG_WR && wel_ff && !busy)
    begin
      pcfg_ff <= sh_ff[15:0];
      pbusy_ff <= 1'b1;
      pcnt_ff <= 16'(PCFG_WR_CYC);
    end
    else if (pbusy_ff)
    begin
      pcnt_ff <= pcnt_ff - 16'h1;
      pbusy_ff <= (pcnt_ff != 16'h1);
    end
  end

  // persistent values taken only at power-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pact_ff <= pcfg_ff;
    end
  end

  // Volatile configuration, applied to outputs at once.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vcfg_ff <= VCFG_RST;
    end
    else if (cs_up && opc_ff == OPC_VCFG_WR && cnt_ff == LEN_VCFG_WR && wel_ff && !busy)
    begin
      vcfg_ff <= sh_ff[7:0];
    end
  end

  // Sticky error flags; a new error wins over a clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      err_ff <= 4'h0;
    end
    else if (cs_up && opc_ff == OPC_FLAG_CLR && cnt_ff == LEN_OPC)
    begin
      err_ff <= err_set;
    end
    else
    begin
      err_ff <= err_ff | err_set;
    end
  end

  // Registered status and write permission for the array side.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fsr_ff <= 8'h00;
      chk_ff <= 1'b0;
    end
    else
    begin
      fsr_ff <= fsr_now;
      chk_ff <= !lock_ff[sec_of(chk_addr)][LK_WRITE];
    end
  end

  assign spi.miso_o = miso_ff;
  assign spi.miso_oe = drv_ff;
  assign chk_allowed = chk_ff;
  assign write_in_progress_flag = pbusy_ff;
  assign write_enable_latch = wel_ff;
  assign flag_status = fsr_ff;
  assign vcfg = vcfg_ff;
  assign pcfg_active = pact_ff;
endmodule

// File: verilog/flc_host.sv
`timescale 1ns/10ps
module flc_host
  import flc_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Serial link.
  flc_spi_if.host spi
);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL, ST_GAP} flc_st_t;

  // Applies byte strobes to a register word.
  function automatic logic [31:0] strb(input logic [31:0] o, input logic [31:0] n,
                                       input logic [3:0] s);
    for (int i = 0; i < 4; i++)
    begin
      strb[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  flc_st_t st_ff;  // Frame sequencer state.
  logic [31:0] cmd_ff;  // Opcode and byte counts.
  logic [31:0] addr_ff;  // Address for the frame.
  logic [31:0] wd_ff;  // Data sent after the address.
  logic [15:0] rx_ff;  // Data received.
  logic [47:0] tx_ff;  // Bits to send, MSB first.
  logic [5:0] bit_ff;  // Bits clocked in this frame.
  logic [2:0] ph_ff;  // Cycle within a clock half or gap.
  logic sclk_ff;
  logic cs_n_ff;
  logic mosi_ff;
  logic [1:0] mi_s;  // Returned data synchroniser.
  logic aw_ff, w_ff;  // Write address and data held.
  logic [7:0] awa_ff;
  logic [31:0] wdat_ff;
  logic [3:0] wstb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  logic [5:0] ntx, ntot;
  logic [47:0] tx_img;
  logic go;
  logic [31:0] cmd_now;  // Command word as it stands once this cycle's write lands.

  assign ntx = LEN_OPC + {1'b0, cmd_ff[CMD_AB_LSB +: 2], 3'h0} +
               {1'b0, cmd_ff[CMD_WB_LSB +: 2], 3'h0};
  assign ntot = ntx + {1'b0, cmd_ff[CMD_RB_LSB +: 2], 3'h0};
  assign go = aw_ff && w_ff && !bvalid_ff && awa_ff == REG_CMD && st_ff == ST_IDLE;
  // The frame starts in the same cycle as the command write, so the image
  // must be built from the new word, not from the one still in the register.
  assign cmd_now = go ? strb(cmd_ff, wdat_ff, wstb_ff) : cmd_ff;

  // Outgoing bit image: opcode, justified address, justified data.
  always_comb
  begin
    tx_img = {cmd_now[7:0], 40'h0};
    tx_img = tx_img | {8'h00, addr_ff[23:0] << (8 * (3 - cmd_now[CMD_AB_LSB +: 2])), 16'h0};
    tx_img = tx_img | ({8'h00, wd_ff[15:0] << (8 * (2 - cmd_now[CMD_WB_LSB +: 2])), 24'h0}
                       >> (8 * cmd_now[CMD_AB_LSB +: 2]));
  end

  // Write channels: either order, response after both.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wdat_ff <= 32'h0;
      wstb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      cmd_ff <= 32'h0;
      addr_ff <= 32'h0;
      wd_ff <= 32'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_ff <= 1'b1;
        awa_ff <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_ff <= 1'b1;
        wdat_ff <= s_wdata;
        wstb_ff <= s_wstrb;
      end
      if (aw_ff && w_ff && !bvalid_ff)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= RESP_OKAY;
        case (awa_ff)
          REG_CMD:
          begin
            // A command while a frame runs is refused.
            if (st_ff == ST_IDLE)
            begin
              cmd_ff <= strb(cmd_ff, wdat_ff, wstb_ff);
            end
            else
            begin
              bresp_ff <= RESP_SLVERR;
            end
          end
          REG_ADDR: addr_ff <= strb(addr_ff, wdat_ff, wstb_ff);
          REG_WDATA: wd_ff <= strb(wd_ff, wdat_ff, wstb_ff);
          default: bresp_ff <= RESP_SLVERR;
        endcase
      end
      else if (bvalid_ff && s_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, unmapped answers an error.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0;
    end
    else if (s_arvalid && s_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      case (s_araddr)
        REG_CMD: rdata_ff <= cmd_ff;
        REG_ADDR: rdata_ff <= addr_ff;
        REG_WDATA: rdata_ff <= wd_ff;
        REG_STAT: rdata_ff <= {31'h0, st_ff != ST_IDLE};
        REG_RDATA: rdata_ff <= {16'h0, rx_ff};
        default:
        begin
          rdata_ff <= 32'h0;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  // Returned data passes two flip-flops before use.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mi_s <= 2'h3;
    end
    else
    begin
      mi_s <= {mi_s[0], spi.miso};
    end
  end

  // Frame sequencer: divided serial clock, mode 0 timing.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= ST_IDLE;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      mosi_ff <= 1'b0;
      tx_ff <= 48'h0;
      rx_ff <= 16'h0;
      bit_ff <= 6'h0;
      ph_ff <= 3'h0;
    end
    else
    begin
      ph_ff <= ph_ff + 3'h1;
      case (st_ff)
        ST_IDLE:
        begin
          ph_ff <= 3'h0;
          if (go && wstb_ff[0])
          begin
            st_ff <= ST_SHIFT;
            cs_n_ff <= 1'b0;
            tx_ff <= tx_img;
            mosi_ff <= tx_img[47];
            bit_ff <= 6'h0;
            // Received data starts from zero so short reads stay right-justified.
            rx_ff <= 16'h0;
          end
        end
        ST_SHIFT:
        begin
          if (ph_ff == 3'(SCK_HALF_CYC - 1))
          begin
            ph_ff <= 3'h0;
            sclk_ff <= !sclk_ff;
            if (sclk_ff)
            begin
              if (bit_ff >= ntx)
              begin
                rx_ff <= {rx_ff[14:0], mi_s[1]};
              end
              tx_ff <= {tx_ff[46:0], 1'b0};
              mosi_ff <= tx_ff[46];
              bit_ff <= bit_ff + 6'h1;
              if (bit_ff == ntot - 6'h1)
              begin
                st_ff <= ST_TAIL;
              end
            end
          end
        end
        ST_TAIL:
        begin
          if (ph_ff == 3'(SCK_HALF_CYC - 1))
          begin
            ph_ff <= 3'h0;
            cs_n_ff <= 1'b1;
            st_ff <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (ph_ff == 3'(MIN_DESEL_CYC + SCK_HALF_CYC))
          begin
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  assign s_awready = !aw_ff && !bvalid_ff;
  assign s_wready = !w_ff && !bvalid_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = !rvalid_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rresp = rresp_ff;
  assign s_rdata = rdata_ff;
  assign spi.cs_n = cs_n_ff;
  assign spi.sclk = sclk_ff;
  assign spi.mosi = mosi_ff;
endmodule

// File: tb/flc_props.sv
`timescale 1ns/10ps
// Wire checks on the serial link joining the host and device ends.
module flc_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A deselect lasts at least the minimum deselect time.
  sequence s_desel;
    cs_n [*3];
  endsequence
  // One serial clock high phase of four clocks.
  sequence s_high;
    sclk [*4] ##1 !sclk;
  endsequence
  property p_oe_off;
    $rose(cs_n) |-> ##[0:6] !miso_oe;
  endproperty
  property p_idle;
    cs_n [*8] |-> !miso_oe;
  endproperty
  property p_desel;
    $rose(cs_n) |-> s_desel;
  endproperty
  property p_cs_end;
    $rose(cs_n) |-> !sclk && !$past(sclk);
  endproperty
  property p_high;
    $rose(sclk) |-> s_high;
  endproperty
  property p_start;
    $fell(cs_n) |-> !sclk [*3];
  endproperty
  property p_mosi;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  property p_miso;
    sclk && $past(sclk) && miso_oe |-> $stable(miso_o);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output drive kept after deselect");
  a_idle: assert property (p_idle) else $error("output driven while deselected");
  a_desel: assert property (p_desel) else $error("deselect too short");
  a_cs_end: assert property (p_cs_end) else $error("deselect with clock high");
  a_high: assert property (p_high) else $error("clock high phase wrong");
  a_start: assert property (p_start) else $error("clock too soon after select");
  a_mosi: assert property (p_mosi) else $error("input line moved while clock high");
  a_miso: assert property (p_miso) else $error("output moved while clock high");
endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps
// Joins both ends and checks them through controller register calls.
module testbench
  import flc_pkg::*;
;
  // Bus, side band and result signals.
  logic aclk, aresetn, ext_busy, chk_allowed, write_in_progress_flag, write_enable_latch;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0] s_awaddr, s_araddr, flag_status, vcfg;
  logic [31:0] s_wdata, s_rdata, q;
  logic [1:0] s_bresp, s_rresp, rs;
  logic [3:0] s_wstrb, err_set;
  logic [23:0] chk_addr;
  logic [15:0] pcfg_active;
  int err_total, cmp_count;
  flc_spi_if spi ();
  flc_host u_flc_host (.spi(spi.host), .*);
  flc_dev u_flc_dev (.spi(spi.dev), .*);
  flc_props u_flc_props (.aclk(aclk), .aresetn(aresetn), .cs_n(spi.cs_n), .sclk(spi.sclk),
    .mosi(spi.mosi), .miso_o(spi.miso_o), .miso_oe(spi.miso_oe));
  // Free running clock.
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A wait that ran out ends the run.
  task automatic tmo();
    err_total++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus write or read; each channel drops valid once taken.
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit dn;
    dn = 1'b0;
    @(posedge aclk);
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= d;
    s_awvalid <= wr;
    s_wvalid <= wr;
    s_arvalid <= !wr;
    s_bready <= wr;
    s_rready <= !wr;
    for (int n = 0; n < 60 && !dn; n++)
    begin
      @(posedge aclk);
      dn = wr ? s_bvalid : s_rvalid;
      q = s_rdata;
      rs = wr ? s_bresp : s_rresp;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_arready) s_arvalid <= 1'b0;
    end
    s_bready <= 1'b0;
    s_rready <= 1'b0;
    if (!dn) tmo();
  endtask
  // Runs one serial frame and leaves the received bits in q.
  task automatic frame(input logic [7:0] op, input logic [1:0] ab, input logic [1:0] wb,
    input logic [1:0] rb, input logic [23:0] ad, input logic [15:0] wd);
    xfer(1'b1, REG_ADDR, {8'h00, ad});
    xfer(1'b1, REG_WDATA, {16'h0000, wd});
    xfer(1'b1, REG_CMD, {18'h00000, rb, wb, ab, op});
    for (int n = 0; n < 400; n++)
    begin
      xfer(1'b0, REG_STAT, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (q[0] !== 1'b0) tmo();
    xfer(1'b0, REG_RDATA, 32'h0);
  endtask
  // Unlocks writes, then writes one sector lock byte.
  task automatic lkw(input logic [23:0] a, input logic [7:0] d);
    frame(OPC_WRITE_UNLOCK, 2'h0, 2'h0, 2'h0, 24'h0, 16'h0);
    frame(OPC_LOCK_WR, 2'h3, 2'h1, 2'h0, a, {8'h00, d});
  endtask
  task automatic lkr(input logic [23:0] a);
    frame(OPC_LOCK_RD, 2'h3, 2'h0, 2'h1, a, 16'h0);
  endtask
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  // Main sequence of tests.
  initial
  begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, ext_busy} = '0;
    {s_awaddr, s_araddr, s_wdata, err_set, chk_addr} = '0;
    s_wstrb = 4'hF;
    err_total = 0;
    cmp_count = 0;
    rst();
    chk(pcfg_active, PCFG_RST, "pcfg_active");
    frame(OPC_FLAG_RD, 2'h0, 2'h0, 2'h2, 24'h0, 16'h0);
    chk(q, 32'h8080, "flag read");
    frame(OPC_ECFG_RD, 2'h0, 2'h0, 2'h1, 24'h0, 16'h0);
    chk(q, ECFG_RST, "enhanced read");
    xfer(1'b0, 8'h40, 32'h0);
    chk(rs, RESP_SLVERR, "unmapped resp");
    xfer(1'b1, 8'h40, 32'h0);
    chk(rs, RESP_SLVERR, "unmapped write resp");
    $display("test resets and reads finished");
    frame(OPC_VCFG_WR, 2'h0, 2'h1, 2'h0, 24'h0, 16'h005A);
    chk(vcfg, VCFG_RST, "vcfg");
    frame(OPC_WRITE_UNLOCK, 2'h0, 2'h0, 2'h0, 24'h0, 16'h0);
    chk(write_enable_latch, 1'b1, "wel");
    frame(OPC_VCFG_WR, 2'h0, 2'h2, 2'h0, 24'h0, 16'h005A);
    chk(vcfg, VCFG_RST, "vcfg");
    frame(OPC_VCFG_WR, 2'h0, 2'h1, 2'h0, 24'h0, 16'h005A);
    chk({write_enable_latch, vcfg}, 9'h05A, "wel and vcfg");
    frame(OPC_VCFG_RD, 2'h0, 2'h0, 2'h1, 24'h0, 16'h0);
    chk(q, 8'h5A, "vcfg read");
    $display("test volatile config finished");
    lkw(24'h120000, 8'h01);
    chk(write_enable_latch, 1'b0, "wel");
    lkr(24'h12ABCD);
    chk(q, 8'h01, "lock read");
    frame(OPC_LOCK_WR, 2'h3, 2'h1, 2'h0, 24'h130000, 16'h0001);
    lkr(24'h130000);
    chk(q, 8'h00, "lock write without latch");
    @(posedge aclk);
    chk_addr <= 24'h12FFFF;
    repeat (3) @(posedge aclk);
    chk(chk_allowed, 1'b0, "allowed");
    chk_addr <= 24'h130000;
    repeat (3) @(posedge aclk);
    chk(chk_allowed, 1'b1, "allowed");
    lkw(24'h120000, 8'h03);
    lkw(24'h120000, 8'h00);
    lkr(24'h120000);
    chk({write_enable_latch, q[7:0]}, 9'h103, "wel and lock");
    $display("test sector lock finished");
    ext_busy <= 1'b1;
    frame(OPC_LOCK_WR, 2'h3, 2'h1, 2'h0, 24'h400000, 16'h0001);
    lkr(24'h400000);
    chk(q, 8'hFF, "busy lock read");
    frame(OPC_FLAG_RD, 2'h0, 2'h0, 2'h1, 24'h0, 16'h0);
    chk(q, 8'h00, "busy flag read");
    ext_busy <= 1'b0;
    lkr(24'h400000);
    chk({write_enable_latch, q[7:0]}, 9'h100, "wel and lock");
    err_set <= 4'hF;
    @(posedge aclk);
    err_set <= 4'h0;
    repeat (3) @(posedge aclk);
    chk(flag_status, 8'hBA, "flags");
    frame(OPC_FLAG_CLR, 2'h0, 2'h0, 2'h0, 24'h0, 16'h0);
    chk({write_enable_latch, flag_status}, 9'h180, "wel and flags");
    frame(OPC_LOCK_WR, 2'h3, 2'h2, 2'h0, 24'h500000, 16'h0101);
    lkr(24'h500000);
    chk(q, 8'h00, "long lock write");
    $display("test busy and flags finished");
    frame(OPC_PCFG_WR, 2'h0, 2'h2, 2'h0, 24'h0, 16'h1234);
    chk(write_in_progress_flag, 1'b1, "wip");
    for (int n = 0; n < 300 && write_in_progress_flag !== 1'b0; n++) @(posedge aclk);
    if (write_in_progress_flag !== 1'b0) tmo();
    chk({write_in_progress_flag, write_enable_latch}, 2'b00, "wip and wel");
    chk(pcfg_active, PCFG_RST, "pcfg_active");
    frame(OPC_PCFG_RD, 2'h0, 2'h0, 2'h2, 24'h0, 16'h0);
    chk(q, 16'h1234, "pcfg read");
    rst();
    chk(pcfg_active, 16'h1234, "pcfg_active");
    lkr(24'h120000);
    chk(q, 8'h00, "lock after reset");
    $display("test persistent config finished");
    print_verdict();
  end
endmodule
